// ===== shared/xwf_pkg.sv
// package: constants and carrier types for the xor-work-with-file datapath
package xwf_pkg;
   // opcode layout: 0001 10da ffff ffff
   localparam logic [5:0] XWF_OPCODE = 6'h06;
   localparam int XWF_OP_MSB = 15;
   localparam int XWF_OP_LSB = 10;
   localparam int XWF_D_POS = 9;
   localparam int XWF_A_POS = 8;
   // indexed literal offset window top, 95
   localparam logic [7:0] XWF_IDX_LIMIT = 8'h5F;
   // access bank: low 96 bytes in bank 0, upper 160 bytes in bank 15
   localparam logic [3:0] XWF_ACC_HI_BANK = 4'hF;
   localparam logic [7:0] XWF_ACC_SPLIT = 8'h60;
   // reset values
   localparam logic [7:0] XWF_W_RST = 8'h00;
   localparam logic [3:0] XWF_BANK_RST = 4'h0;
   localparam logic [15:0] XWF_INSN_RST = 16'h0000;
   // quarter phases
   typedef enum logic [3:0] {
      XWF_Q1 = 4'h1,
      XWF_Q2 = 4'h2,
      XWF_Q3 = 4'h4,
      XWF_Q4 = 4'h8
   } xwf_phase_t;
   // file memory request from the core
   typedef struct packed {
      logic rd;
      logic wr;
      logic [11:0] addr;
      logic [7:0] wdata;
   } xwf_file_req_t;
   // result flags
   typedef struct packed {
      logic neg;
      logic zero;
   } xwf_flags_t;
endpackage : xwf_pkg

// ===== core/xwf_addr_resolve.sv
// file address resolution: access bank, banked memory, indexed offset
`timescale 1ns/1ps
`default_nettype none
module xwf_addr_resolve (
   // instruction fields
   input wire logic [7:0] f_field,
   input wire logic acc_bit,
   // machine state
   input wire logic [3:0] bank_sel,
   input wire logic ext_en,
   input wire logic [11:0] index_base,
   // resolved address
   output logic [11:0] addr
);
   import xwf_pkg::*;
   // pick the 12-bit address from the addressing mode in force
   always_comb begin
      if (acc_bit) begin
         addr = {bank_sel, f_field};
      end else if (ext_en && (f_field <= XWF_IDX_LIMIT)) begin
         // indexed literal offset; wraps at 4 KB like the pointer
         addr = index_base + {4'h0, f_field};
      end else if (f_field < XWF_ACC_SPLIT) begin
         addr = {XWF_BANK_RST, f_field};
      end else begin
         // access bank upper 160 bytes, special registers
         addr = {XWF_ACC_HI_BANK, f_field};
      end
   end
endmodule // xwf_addr_resolve
`default_nettype wire

// ===== core/xwf_core.sv
// xor-work-with-file execution unit, one instruction per four quarters
// How it works
// - the result is working register xor file register, sent to the chosen destination.
// - with the destination bit clear the result goes to the working register only.
// - with the destination bit set the result is written back to the file register.
// - with the bank access bit clear the address is taken in the access bank, except for extended-mode indexed offsets.
// - with the bank access bit set the bank select register picks the bank.
// - extended mode with access bit clear treats addresses up to 95 as indexed offsets.
`timescale 1ns/1ps
`default_nettype none
module xwf_core (
   // clock and reset
   input wire logic mclk,
   input wire logic srst,
   // instruction and mode
   input wire logic [15:0] insn,
   input wire logic insn_valid,
   input wire logic ext_en,
   input wire logic [3:0] bank_select_register,
   input wire logic [11:0] index_base,
   // file memory
   output xwf_pkg::xwf_file_req_t file_req,
   input wire logic [7:0] file_rdata,
   // results
   output logic [7:0] work_reg,
   output xwf_pkg::xwf_flags_t flags,
   output logic flags_upd,
   output xwf_pkg::xwf_phase_t phase,
   output logic done
);
   import xwf_pkg::*;

   xwf_phase_t ph_q, ph_d;
   logic [15:0] ir_q, ir_d;
   logic act_q, act_d;
   logic [7:0] res_q, res_d;
   logic [7:0] w_q, w_d;
   xwf_flags_t fl_q, fl_d;
   logic fl_upd_q, fl_upd_d;
   logic done_q, done_d;
   xwf_file_req_t req_q, req_d;
   logic [11:0] addr;

   // true when the latched word is this instruction
   function automatic logic is_xwf(input logic [15:0] w);
      is_xwf = (w[XWF_OP_MSB:XWF_OP_LSB] == XWF_OPCODE);
   endfunction

   // address built combinationally so the read set up in Q2 is presented in Q3
   xwf_addr_resolve u_addr (
      .f_field(ir_q[7:0]),
      .acc_bit(ir_q[XWF_A_POS]),
      .bank_sel(bank_select_register),
      .ext_en(ext_en),
      .index_base(index_base),
      .addr(addr)
   );

   // next state of the quarter sequencer and datapath
   always_comb begin
      ph_d = ph_q;
      ir_d = ir_q;
      act_d = act_q;
      res_d = res_q;
      w_d = w_q;
      fl_d = fl_q;
      fl_upd_d = 1'b0;
      done_d = 1'b0;
      req_d = '0;
      req_d.addr = req_q.addr;
      case (ph_q)
         XWF_Q1: begin
            ir_d = insn;
            act_d = insn_valid && is_xwf(insn);
            ph_d = XWF_Q2;
         end
         XWF_Q2: begin
            req_d.rd = act_q;
            req_d.addr = addr;
            ph_d = XWF_Q3;
         end
         XWF_Q3: begin
            res_d = w_q ^ file_rdata;
            ph_d = XWF_Q4;
         end
         XWF_Q4: begin
            if (act_q) begin
               if (ir_q[XWF_D_POS]) begin
                  req_d.wr = 1'b1;
                  req_d.wdata = res_q;
               end else begin
                  w_d = res_q;
               end
               fl_d.neg = res_q[7];
               fl_d.zero = (res_q == 8'h00);
               fl_upd_d = 1'b1;
               done_d = 1'b1;
            end
            act_d = 1'b0;
            ph_d = XWF_Q1;
         end
         default: begin
            // illegal phase code recovers to decode
            ph_d = XWF_Q1;
            act_d = 1'b0;
         end
      endcase
   end

   // registers only
   always_ff @(posedge mclk) begin
      if (srst) begin
         ph_q <= XWF_Q1;
         ir_q <= XWF_INSN_RST;
         act_q <= 1'b0;
         res_q <= 8'h00;
         w_q <= XWF_W_RST;
         fl_q <= '0;
         fl_upd_q <= 1'b0;
         done_q <= 1'b0;
         req_q <= '0;
      end else begin
         ph_q <= ph_d;
         ir_q <= ir_d;
         act_q <= act_d;
         res_q <= res_d;
         w_q <= w_d;
         fl_q <= fl_d;
         fl_upd_q <= fl_upd_d;
         done_q <= done_d;
         req_q <= req_d;
      end
   end

   // outputs straight from flops
   assign file_req = req_q;
   assign work_reg = w_q;
   assign flags = fl_q;
   assign flags_upd = fl_upd_q;
   assign phase = ph_q;
   assign done = done_q;
endmodule // xwf_core
`default_nettype wire

// ===== verif/xwf_core_sva.sv
// checker for the xor-work-with-file execution unit
`timescale 1ns/1ps
`default_nettype none
module xwf_core_sva (
   // watched ports
   input wire logic mclk,
   input wire logic srst,
   input wire logic [15:0] insn,
   input wire logic insn_valid,
   input wire logic [3:0] bank_select_register,
   input wire xwf_pkg::xwf_file_req_t file_req,
   input wire logic [7:0] file_rdata,
   input wire logic [7:0] work_reg,
   input wire xwf_pkg::xwf_flags_t flags,
   input wire logic flags_upd,
   input wire xwf_pkg::xwf_phase_t phase,
   input wire logic done
);
   import xwf_pkg::*;
   // one domain, so clock and reset are given once
   default clocking @(posedge mclk); endclocking
   default disable iff (srst);
   phase_step_a: assert property (phase == XWF_Q1 |=> phase == XWF_Q2)
      else $error("quarter order broken");
   read_slot_a: assert property (file_req.rd |-> phase == XWF_Q3
      ##2 done && flags_upd) else $error("read or done out of slot");
   bank_pick_a: assert property (phase == XWF_Q1 && insn_valid &&
      insn[15:10] == XWF_OPCODE && insn[XWF_A_POS] |-> ##2 file_req.rd &&
      file_req.addr[11:8] == $past(bank_select_register))
      else $error("bank not taken from select register");
   file_xor_a: assert property (file_req.rd ##2 file_req.wr |->
      file_req.wdata == ($past(work_reg, 2) ^ $past(file_rdata, 2)))
      else $error("file write data wrong");
   work_xor_a: assert property (file_req.rd ##2 !file_req.wr |->
      work_reg == ($past(work_reg, 2) ^ $past(file_rdata, 2)))
      else $error("working register result wrong");
   work_keep_a: assert property (file_req.wr |-> $stable(work_reg))
      else $error("working register changed on file write");
   flag_work_a: assert property (flags_upd && !file_req.wr |->
      flags.neg == work_reg[7] && flags.zero == (work_reg == 8'h00))
      else $error("flags wrong for working result");
   flag_file_a: assert property (file_req.wr |-> flags_upd &&
      flags.neg == file_req.wdata[7] && flags.zero == (file_req.wdata == 8'h00))
      else $error("flags wrong for file result");
endmodule // xwf_core_sva
bind xwf_core xwf_core_sva i_xwf_core_sva (.mclk, .srst, .insn, .insn_valid,
   .bank_select_register, .file_req, .file_rdata, .work_reg, .flags,
   .flags_upd, .phase, .done);
`default_nettype wire

// ===== verif/test_xwf_core.sv
// self-checking bench for the xor-work-with-file execution unit
`timescale 1ns/1ps
`default_nettype none
module test_xwf_core;
   import xwf_pkg::*;
   // design ports and model state
   logic mclk = 1'h0, srst = 1'h1, insn_valid = 1'h0, ext_en = 1'h0;
   logic [15:0] insn = 16'h0000, lfsr = 16'h5C81;
   logic [3:0] bank_select_register = 4'h0;
   logic [11:0] index_base = 12'h000;
   logic [7:0] file_rdata = 8'h00, w = 8'h00, work_reg;
   xwf_file_req_t file_req;
   xwf_flags_t flags;
   xwf_phase_t phase;
   logic flags_upd, done;
   int miscompares = 0, total_checks = 0, cyc = 0;
   xwf_core i_xwf_core (.mclk, .srst, .insn, .insn_valid, .ext_en,
      .bank_select_register, .index_base, .file_req, .file_rdata,
      .work_reg, .flags, .flags_upd, .phase, .done);
   initial forever #5 mclk = ~mclk;
   // fixed-seed pseudo random source
   function automatic logic [15:0] rnd();
      lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      return lfsr;
   endfunction
   task automatic cmp(input logic [11:0] got, input logic [11:0] exp);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic stop_test();
      if (miscompares == 0 && total_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // one instruction slot; bad slots are refused opcodes or invalid words
   task automatic op(input logic bad);
      logic [15:0] i, j, k;
      logic [11:0] ea;
      logic [7:0] r;
      logic take;
      i = rnd();
      j = rnd();
      k = rnd();
      take = ~bad;
      i[15:10] = XWF_OPCODE | {5'h00, bad & i[0]};
      #1;
      while (phase !== XWF_Q1) begin
         @(posedge mclk);
         #1;
      end
      insn <= i;
      insn_valid <= ~bad | i[0];
      bank_select_register <= j[3:0];
      ext_en <= j[4];
      index_base <= k[11:0];
      // address the model expects for this word
      if (i[8]) ea = {j[3:0], i[7:0]};
      else if (j[4] && i[7:0] <= XWF_IDX_LIMIT) ea = k[11:0] + {4'h0, i[7:0]};
      else ea = {(i[7:0] < XWF_ACC_SPLIT) ? 4'h0 : XWF_ACC_HI_BANK, i[7:0]};
      repeat (2) @(posedge mclk);
      #1;
      file_rdata <= j[15:8];
      cmp(file_req.rd, take);
      cmp(phase, {8'h00, XWF_Q3});
      if (take) cmp(file_req.addr, ea);
      repeat (2) @(posedge mclk);
      #1;
      r = w ^ j[15:8];
      cmp(done, take);
      cmp(flags_upd, take);
      cmp(file_req.wr, take & i[9]);
      if (take & i[9]) cmp(file_req.wdata, r);
      else if (take) w = r;
      cmp(work_reg, w);
      if (take) cmp({flags.neg, flags.zero}, {r[7], r == 8'h00});
   endtask
   // hang guard, well above the 200 slots of four cycles each
   always @(posedge mclk) begin
      cyc++;
      if (cyc > 3000) begin
         miscompares++;
         stop_test();
      end
   end
   initial begin
      repeat (8) @(posedge mclk);
      srst <= 1'h0;
      for (int n = 0; n < 200; n++) op(n % 8 == 7);
      stop_test();
   end
endmodule // test_xwf_core
`default_nettype wire
